/* lbr_regulator_ctrl.sv */
// Control logic for the LCD bias regulator: one control register on
// Wishbone, decoded into four bias configurations and analog controls.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
//
// Functional notes
// - Control register: pump enable bit 7, bit 6 zero, peak 5:3, third 2, clock 1:0.
// - Reset clears pump enable and clock select, sets peak code and third bias.
// - Pump enable one turns the charge pump on while the clock is on; zero keeps it off.
// - Peak code passes to regulator; 111 is 3.60V, each step down 0.13V.
// - Third-bias bit one selects one-third bias in regulator configurations, zero selects static bias.
// - Clock select: 11 low-power RC, 10 fast RC, 01 secondary, 00 off.
// - Clock on and pump enabled gives the boosted regulator configuration.
// - Clock on and pump disabled gives the unboosted regulator configuration.
// - Regulator configurations offer only static and one-third bias types.
// - Clock off, pump enabled: pump off, reference drives bottom bias pin.
// - In soft-contrast ladder mode the flyback pins become general I/O.
// - Clock off, pump disabled: regulator and reference off, ladder grounded.
// - In hardware-contrast mode the peak code has no effect.
`timescale 1ns/10ps
`default_nettype none

module lbr_regulator_ctrl
    import lbr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Analog regulator controls
    output logic             charge_pump_enable_o,
    output logic             regulator_enable_o,
    output logic             reference_enable_o,
    output logic [1:0]       regulator_clock_select_o,
    output logic [2:0]       peak_level_code_o,
    output logic             third_bias_select_o,
    output logic             bottom_bias_drive_o,
    output logic             flyback_pins_as_io_o,
    output logic             boosted_regulator_cfg_o,
    output logic             unboosted_regulator_cfg_o,
    output logic             ladder_soft_contrast_cfg_o,
    output logic             ladder_hard_contrast_cfg_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration decode, shared by status readback and outputs

    function automatic lbr_cfg_type lbr_decode_cfg(input logic [7:0] ctrl);
        logic clk_on;
        clk_on = (ctrl[LBR_CLKSEL_MSB:LBR_CLKSEL_LSB] != LBR_CLK_OFF);
        if (clk_on && ctrl[LBR_CHARGE_PUMP_ENABLE_BIT]) begin
            lbr_decode_cfg = LBR_CFG_BOOST;
        end else if (clk_on) begin
            lbr_decode_cfg = LBR_CFG_NOBOOST;
        end else if (ctrl[LBR_CHARGE_PUMP_ENABLE_BIT]) begin
            lbr_decode_cfg = LBR_CFG_SOFTLAD;
        end else begin
            lbr_decode_cfg = LBR_CFG_HARDLAD;
        end
    endfunction : lbr_decode_cfg

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic        ack_r;
    logic        err_r;
    logic [31:0] dat_r;

    wire         req_new   = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
    wire         hit_ctrl  = (wb_adr_i == LBR_REG_CTRL_OFS);
    wire         hit_stat  = (wb_adr_i == LBR_REG_STATUS_OFS);
    wire         hit_any   = hit_ctrl | hit_stat;
    wire         wr_ctrl   = req_new & wb_we_i & hit_ctrl & wb_sel_i[0];
    // Bit 6 is never stored so it always reads zero
    assign ctrl_nxt = wr_ctrl ? (wb_dat_i[7:0] & LBR_CTRL_WMASK) : ctrl_r;

    wire lbr_cfg_type cfg_now  = lbr_decode_cfg(ctrl_r);
    wire lbr_cfg_type cfg_nxt  = lbr_decode_cfg(ctrl_nxt);

    // Status shows the configuration held before a same-cycle write
    wire [31:0]  ctrl_rd = {24'h00_0000, ctrl_r};
    wire [31:0]  stat_rd = {30'h0000_0000, cfg_now};
    wire [31:0]  rd_mux  = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd : 32'h0000_0000;
    // Read data stands only with the ack, zero otherwise
    wire [31:0]  dat_nxt = (req_new & ~wb_we_i) ? rd_mux : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Register and bus response, one wait-free cycle of latency

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl_r <= LBR_CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Held strobe ignored while ack stands: one request, one answer
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req_new & hit_any;
        end
    end

    // Unmapped address answers with err so the master never waits forever
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            err_r <= 1'b0;
        end else begin
            err_r <= req_new & ~hit_any;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            dat_r <= 32'h0000_0000;
        end else begin
            dat_r <= dat_nxt;
        end
    end

    // Bus outputs straight from their flops
    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = dat_r;

    ////////////////////////////////////////////////////////////////////////////
    // Analog controls, registered from the next control value so they
    // settle in the cycle after the write, together with the ack

    // Four exclusive configuration flags from one decode
    wire boost_n  = (cfg_nxt == LBR_CFG_BOOST);
    wire nobst_n  = (cfg_nxt == LBR_CFG_NOBOOST);
    wire soft_n   = (cfg_nxt == LBR_CFG_SOFTLAD);
    wire hard_n   = (cfg_nxt == LBR_CFG_HARDLAD);
    wire reg_on_n = boost_n | nobst_n;

    // Pump runs only when boosted; soft ladder keeps it off
    wire         pump_nxt    = boost_n;
    wire         reg_en_nxt  = reg_on_n;
    // Reference stays up in the soft ladder to set the ladder bottom
    wire         ref_en_nxt  = reg_on_n | soft_n;
    wire [1:0]   clk_sel_nxt = ctrl_nxt[LBR_CLKSEL_MSB:LBR_CLKSEL_LSB];
    // Code ignored when hard contrast: hold max, no offset
    wire [2:0]   peak_nxt    = hard_n ? LBR_PEAK_MAX
                                      : ctrl_nxt[LBR_PEAK_MSB:LBR_PEAK_LSB];
    // Ladder configurations get their bias type from the resistors
    wire         third_nxt   = reg_on_n & ctrl_nxt[LBR_THIRD_BIT];
    wire         bottom_nxt  = ~hard_n;
    wire         io_pins_nxt = soft_n;

    ////////////////////////////////////////////////////////////////////////////
    // Output registers: one short process per control keeps each reset
    // value beside its flop; reset values match the power-on decode

    logic        pump_r;
    logic        reg_en_r;
    logic        ref_en_r;
    logic [1:0]  clk_sel_r;
    logic [2:0]  peak_r;
    logic        third_r;
    logic        bottom_r;
    logic        io_pins_r;
    logic        boost_r;
    logic        nobst_r;
    logic        soft_r;
    logic        hard_r;

    // Pump starts off whatever the register holds
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pump_r <= 1'b0;
        end else begin
            pump_r <= pump_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            reg_en_r <= 1'b0;
        end else begin
            reg_en_r <= reg_en_nxt;
        end
    end

    // Reference off at power-on: hard contrast needs no reference
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ref_en_r <= 1'b0;
        end else begin
            ref_en_r <= ref_en_nxt;
        end
    end

    // Clock code passes through; 00 also stops the regulator
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            clk_sel_r <= LBR_CLK_OFF;
        end else begin
            clk_sel_r <= clk_sel_nxt;
        end
    end

    // Peak code at its top value, no low-side offset
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            peak_r <= LBR_PEAK_MAX;
        end else begin
            peak_r <= peak_nxt;
        end
    end

    // Regulator off at reset, so the third-bias request is not passed on
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            third_r <= 1'b0;
        end else begin
            third_r <= third_nxt;
        end
    end

    // Bottom of the ladder at ground until a reference is running
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bottom_r <= 1'b0;
        end else begin
            bottom_r <= bottom_nxt;
        end
    end

    // Flyback pins stay with the pump unless the soft ladder frees them
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            io_pins_r <= 1'b0;
        end else begin
            io_pins_r <= io_pins_nxt;
        end
    end

    // Flags share one decode so only one is ever high
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            boost_r <= 1'b0;
        end else begin
            boost_r <= boost_n;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            nobst_r <= 1'b0;
        end else begin
            nobst_r <= nobst_n;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            soft_r <= 1'b0;
        end else begin
            soft_r <= soft_n;
        end
    end

    // Hard contrast is the power-on configuration
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            hard_r <= 1'b1;
        end else begin
            hard_r <= hard_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output ports, each straight from its register

    assign charge_pump_enable_o       = pump_r;
    assign regulator_enable_o         = reg_en_r;
    assign reference_enable_o         = ref_en_r;
    assign regulator_clock_select_o   = clk_sel_r;
    assign peak_level_code_o          = peak_r;
    assign third_bias_select_o        = third_r;
    assign bottom_bias_drive_o        = bottom_r;
    assign flyback_pins_as_io_o       = io_pins_r;
    assign boosted_regulator_cfg_o    = boost_r;
    assign unboosted_regulator_cfg_o  = nobst_r;
    assign ladder_soft_contrast_cfg_o = soft_r;
    assign ladder_hard_contrast_cfg_o = hard_r;

endmodule : lbr_regulator_ctrl

`default_nettype wire

/* lbr_pkg.sv */
// Package for the LCD bias regulator control block.
// Assumes a 32-bit classic Wishbone register bus, byte addresses.
package lbr_pkg;

    // Register map
    localparam logic [7:0] LBR_REG_CTRL_OFS    = 8'h00;
    localparam logic [7:0] LBR_REG_STATUS_OFS  = 8'h04;

    // Control field positions
    localparam int LBR_CHARGE_PUMP_ENABLE_BIT     = 7;
    localparam int LBR_UNUSED_BIT   = 6;
    localparam int LBR_PEAK_LSB     = 3;
    localparam int LBR_PEAK_MSB     = 5;
    localparam int LBR_THIRD_BIT    = 2;
    localparam int LBR_CLKSEL_LSB   = 0;
    localparam int LBR_CLKSEL_MSB   = 1;

    // Power-on value: pump off, peak code all ones, third bias on, clock off
    localparam logic [7:0] LBR_CTRL_RESET = 8'h3C;
    localparam logic [7:0] LBR_CTRL_WMASK = 8'hBF;

    // Peak code that leaves the low-side offset at zero
    localparam logic [2:0] LBR_PEAK_MAX   = 3'h7;

    typedef enum logic [1:0] {
        LBR_CLK_OFF  = 2'b00,
        LBR_CLK_SECONDARY_OSC = 2'b01,
        LBR_CLK_FRC  = 2'b10,
        LBR_CLK_LOW_POWER_RC_OSC = 2'b11
    } lbr_clksel_type;

    typedef enum logic [1:0] {
        LBR_CFG_BOOST   = 2'b00,
        LBR_CFG_NOBOOST = 2'b01,
        LBR_CFG_SOFTLAD = 2'b10,
        LBR_CFG_HARDLAD = 2'b11
    } lbr_cfg_type;

endpackage : lbr_pkg

/* lbr_analog_model.sv */
// Behavioural regulator and pump: span between top and bottom bias pins in mV.
// Fed by the control block outputs; supply level is a plain parameter.
`timescale 1ns/10ps
`default_nettype none
module lbr_analog_model #(
    parameter int SUPPLY_MV = 3300
) (
    input  wire logic        pump_i,
    input  wire logic        reg_i,
    input  wire logic [2:0]  code_i,
    output logic      [11:0] span_mv_o
);
    wire logic [11:0] raw_mv = 12'hE10 - 12'h082 * (12'h007 - {9'h000, code_i});
    // No pump, so the span stops at the supply
    assign span_mv_o = !reg_i ? 12'h000
                     : (pump_i || raw_mv < SUPPLY_MV) ? raw_mv : 12'(SUPPLY_MV);
endmodule : lbr_analog_model
`default_nettype wire

/* lbr_regulator_ctrl_sva.sv */
// Port assertions for the regulator control block.
// Bound to each instance; one clock, reset active low.
`timescale 1ns/10ps
`default_nettype none
module lbr_regulator_ctrl_sva (
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       wb_err_o,
    input wire logic       charge_pump_enable_o,
    input wire logic       regulator_enable_o,
    input wire logic       reference_enable_o,
    input wire logic [1:0] regulator_clock_select_o,
    input wire logic [2:0] peak_level_code_o,
    input wire logic       third_bias_select_o,
    input wire logic       bottom_bias_drive_o,
    input wire logic       flyback_pins_as_io_o,
    input wire logic       boosted_regulator_cfg_o,
    input wire logic       unboosted_regulator_cfg_o,
    input wire logic       ladder_soft_contrast_cfg_o,
    input wire logic       ladder_hard_contrast_cfg_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    wire logic [3:0] cfg = {boosted_regulator_cfg_o, unboosted_regulator_cfg_o,
                            ladder_soft_contrast_cfg_o, ladder_hard_contrast_cfg_o};
    wire logic       clk_on = regulator_clock_select_o != 2'h0;
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
    sequence s_one; (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o); endsequence
    property p_answer; s_req |=> s_one; endproperty
    a_answer: assert property (p_answer) else $error("bus answer");
    property p_onehot; $onehot(cfg); endproperty
    a_onehot: assert property (p_onehot) else $error("cfg not one-hot");
    property p_boost; boosted_regulator_cfg_o == (charge_pump_enable_o && clk_on); endproperty
    a_boost: assert property (p_boost) else $error("boost cfg");
    property p_noboost;
        unboosted_regulator_cfg_o == (regulator_enable_o && !charge_pump_enable_o);
    endproperty
    a_noboost: assert property (p_noboost) else $error("unboosted cfg");
    property p_regclk; regulator_enable_o == clk_on; endproperty
    a_regclk: assert property (p_regclk) else $error("regulator clock");
    property p_pins; flyback_pins_as_io_o == ladder_soft_contrast_cfg_o; endproperty
    a_pins: assert property (p_pins) else $error("flyback pins");
    property p_ref; reference_enable_o == !ladder_hard_contrast_cfg_o; endproperty
    a_ref: assert property (p_ref) else $error("reference");
    property p_hard; ladder_hard_contrast_cfg_o |-> peak_level_code_o == 3'h7; endproperty
    a_hard: assert property (p_hard) else $error("hard peak code");
    property p_third; third_bias_select_o |-> regulator_enable_o; endproperty
    a_third: assert property (p_third) else $error("third bias");
    property p_change; !$stable(cfg) |-> wb_ack_o; endproperty
    a_change: assert property (p_change) else $error("cfg moved alone");
    property p_soft;
        ladder_soft_contrast_cfg_o |-> !charge_pump_enable_o && reference_enable_o
                                       && bottom_bias_drive_o;
    endproperty
    a_soft: assert property (p_soft) else $error("soft ladder controls");
endmodule : lbr_regulator_ctrl_sva
bind lbr_regulator_ctrl lbr_regulator_ctrl_sva lbr_regulator_ctrl_sva_i (.*);
`default_nettype wire

/* lbr_regulator_ctrl_test.sv */
// Self-checking bench: Wishbone master, read results checked through a queue.
// Assumes the control block, its package and the analog model.
`timescale 1ns/10ps
`default_nettype none
module lbr_regulator_ctrl_test;
    import lbr_pkg::*;
    logic        clk_i = 1'b0, rst_b_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00, v, s = 8'h1B;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
    logic        wb_ack_o, wb_err_o, charge_pump_enable_o, regulator_enable_o, on;
    logic        reference_enable_o, third_bias_select_o, bottom_bias_drive_o;
    logic        flyback_pins_as_io_o, boosted_regulator_cfg_o, unboosted_regulator_cfg_o;
    logic        ladder_soft_contrast_cfg_o, ladder_hard_contrast_cfg_o;
    logic [1:0]  regulator_clock_select_o;
    logic [2:0]  peak_level_code_o;
    logic [11:0] span_mv;
    logic [32:0] q[$];
    int          bad_count = 0, checks = 0;
    lbr_regulator_ctrl lbr_regulator_ctrl_i (.*);
    lbr_analog_model lbr_analog_model_i (.pump_i(charge_pump_enable_o),
        .reg_i(regulator_enable_o), .code_i(peak_level_code_o), .span_mv_o(span_mv));
    always #5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] nx(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : nx
    task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] m);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, m};
        do @(posedge clk_i); while ((wb_ack_o | wb_err_o) !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
    endtask : rd
    task automatic chk(input logic [7:0] c);
        logic        en;
        logic        pe;
        logic [11:0] mv;
        en = c[1:0] != 2'h0;
        pe = c[7];
        mv = 12'(3600 - 130 * (7 - int'(c[5:3])));
        cmp("analog", {18'h0_0000, (en | pe) ? c[5:3] : 3'h7, en & pe, !en & pe,
            en & c[2], c[1:0], en, en | pe, en | pe, en & pe, en & !pe, !en & pe, !en & !pe},
            {18'h0_0000, peak_level_code_o, charge_pump_enable_o, flyback_pins_as_io_o,
            third_bias_select_o, regulator_clock_select_o, regulator_enable_o,
            reference_enable_o, bottom_bias_drive_o, boosted_regulator_cfg_o,
            unboosted_regulator_cfg_o, ladder_soft_contrast_cfg_o,
            ladder_hard_contrast_cfg_o});
        cmp("span_mv", {21'h00_0000, !en ? 12'h000 : (pe || mv < 12'hCE4) ? mv : 12'hCE4},
            {21'h00_0000, span_mv});
    endtask : chk
    task automatic end_sim;
        if (bad_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i)
        if ((wb_ack_o | wb_err_o) === 1'b1 && !wb_we_i && q.size() > 0)
            cmp("wb_dat_o", q.pop_front(), {wb_err_o, wb_dat_o});
    initial begin
        #20000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(LBR_REG_CTRL_OFS, 33'h0_0000_003C);
        rd(LBR_REG_STATUS_OFS, 33'h0_0000_0003);
        chk(LBR_CTRL_RESET);
        for (int i = 0; i < 24; i++) begin
            s = nx(s);
            v = {i[2], s[6:2], i[1:0]};
            on = v[1:0] != 2'h0;
            bus(1'b1, LBR_REG_CTRL_OFS, {24'h00_0000, v}, 4'hF);
            rd(LBR_REG_CTRL_OFS, {25'h000_0000, v & 8'hBF});
            rd(LBR_REG_STATUS_OFS, {31'h0000_0000, !on, !v[7]});
            chk(v);
        end
        bus(1'b1, LBR_REG_CTRL_OFS, 32'h0000_0000, 4'hE);
        rd(LBR_REG_CTRL_OFS, {25'h000_0000, v & 8'hBF});
        rd(8'h08, 33'h1_0000_0000);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(LBR_REG_CTRL_OFS, {25'h000_0000, LBR_CTRL_RESET});
        chk(LBR_CTRL_RESET);
        end_sim();
    end
endmodule : lbr_regulator_ctrl_test
`default_nettype wire
